// ### core/wdtrt_pkg.sv
// Contract
// RQ1: counter runs freely; software restarts it periodically
// RQ2: missed restart forces reset, optional interrupt first
// RQ3: four timeouts from 2^12 to 2^21 clocks
// RQ4: interrupt comes 512 clocks before reset
// RQ5: watchdog reset sets reset-cause flag in control
// RQ6: execution restarts at 8000h after watchdog reset
// RQ7: interrupt flag sets even when interrupt disabled
// RQ8: two-bit select; restart write clears counter
package wdtrt_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, word aligned)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;  // watchdog_control_register
    localparam logic [3:0] ADDR_STATUS = 4'h4;  // sticky event status, read clears
    localparam logic [3:0] ADDR_MASK   = 4'h8;  // interrupt mask
    localparam logic [3:0] ADDR_COUNT  = 4'hC;  // live counter value

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_SEL_LSB   = 0;  // two-bit interval select
    localparam int CTRL_RST_EN    = 2;  // watchdog reset enable
    localparam int CTRL_IRQ_EN    = 3;  // early-warning interrupt enable
    localparam int CTRL_RESTART   = 4;  // write 1 restarts counter
    localparam int CTRL_WARN_FLAG = 5;  // early-warning flag, write 0 clears
    localparam int CTRL_CAUSE     = 6;  // watchdog_reset_cause_flag, write 0 clears

    // status bits
    localparam int STAT_WARN  = 0;
    localparam int STAT_RESET = 1;

    // ------------------------------------------------------------
    // timing and reset values
    // ------------------------------------------------------------
    localparam int WARN_LEAD_CLKS    = 512;      // warning lead before reset
    localparam int RESET_PULSE_CLKS  = 16;       // length of system reset pulse
    localparam logic [15:0] RESTART_VECTOR = 16'h8000;
    localparam logic [1:0]  SEL_RESET      = 2'h0;
    localparam int SEL_EXP0 = 12;                // interval exponent of code 0
    localparam int SEL_STEP = 3;                 // exponent step per code

endpackage : wdtrt_pkg

// ### core/wdtrt_cfg_if.sv
`timescale 1ns/1ps
// control settings passed to the counter core
interface wdtrt_cfg_if;
    logic [1:0] sel;        // interval select
    logic       restart;    // one-cycle restart pulse
    logic       warn;       // one-cycle warning pulse
    logic       expire;     // one-cycle expiry pulse
    logic [21:0] count;     // live count
    modport ctl  (output sel, output restart, input warn, input expire, input count);
    modport core (input sel, input restart, output warn, output expire, output count);
endinterface : wdtrt_cfg_if

// ### core/wdtrt_counter.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// free-running watchdog counter with warning and expiry taps
// ------------------------------------------------------------
module wdtrt_counter #(
    parameter int CNT_W = 22
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // settings and events
    wdtrt_cfg_if.core cfg
);
    logic [CNT_W-1:0] cnt_q;      // running count
    logic [CNT_W-1:0] limit;      // length of the chosen interval; expiry fires at limit - 1
    logic [CNT_W-1:0] warn_at;    // the warning fires one count before this value
    logic [9:0]       since_q;    // checker helper: cycles since the last warning

    // interval table: 2^12, 2^15, 2^18, 2^21
    assign limit   = CNT_W'(1) << (wdtrt_pkg::SEL_EXP0 + wdtrt_pkg::SEL_STEP * int'(cfg.sel)); // RQ3 RQ8
    assign warn_at = limit - CNT_W'(wdtrt_pkg::WARN_LEAD_CLKS);                                // RQ4
    assign cfg.count = cnt_q;

    // counter: restart clears, expiry wraps to zero
    always_ff @(posedge core_clk) begin
        if (rst || cfg.restart || cfg.expire) begin
            cnt_q <= '0;                       // RQ8
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);        // RQ1
        end
    end

    // events are combinational on the count; parent registers them
    assign cfg.warn   = !cfg.restart && (cnt_q == warn_at - CNT_W'(1));
    assign cfg.expire = !cfg.restart && (cnt_q == limit - CNT_W'(1));   // RQ2

    a_cnt_restart: assert property (@(posedge core_clk) disable iff (rst)
        cfg.restart |=> cnt_q == '0) else $error("restart did not clear counter"); // RQ8
    // helper count: a long lead is checked on a counter, not by repetition
    always_ff @(posedge core_clk) begin
        if (rst || cfg.restart) begin
            since_q <= 10'h000;                // restart starts a new interval
        end else if (cfg.warn) begin
            since_q <= 10'h001;
        end else if (since_q != 10'h000 && since_q != 10'h3FF) begin
            since_q <= since_q + 10'h001;      // saturates, never wraps
        end
    end

    a_cnt_warn_lead: assert property (@(posedge core_clk) disable iff (rst)
        cfg.expire |-> since_q == 10'(wdtrt_pkg::WARN_LEAD_CLKS)) // RQ4
        else $error("expiry not 512 clocks after warning");
endmodule : wdtrt_counter

// ### core/wdtrt_top.sv
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ps
// ------------------------------------------------------------
// watchdog reset timer with Avalon-MM register slave
// ------------------------------------------------------------
module wdtrt_top (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // system outputs
    output logic             irq,
    output logic             sys_reset,
    output logic      [15:0] restart_vector
);
    wdtrt_cfg_if cfg_if ();

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0] sel_q;        // interval select
    logic       rst_en_q;     // reset enable
    logic       irq_en_q;     // warning interrupt enable
    logic       warn_flag_q;  // warning flag in control register
    logic       cause_q;      // watchdog_reset_cause_flag
    logic [1:0] stat_q;       // sticky status, read clears
    logic [1:0] mask_q;       // interrupt mask
    logic [4:0] rpulse_q;     // reset pulse down-counter
    logic       ack_q;        // answer phase of bus cycle
    logic       wait_q;       // waitrequest, straight from a flop
    logic [15:0] rvec_q;      // restart address, held in a flop
    logic       irq_q;
    logic       sys_reset_q;

    // ------------------------------------------------------------
    // decode: one wait state, answer on second cycle
    // ------------------------------------------------------------
    wire req       = (avs_read || avs_write) && !ack_q;
    // writes land on the answer edge, when waitrequest is low
    wire ack       = (avs_read || avs_write) && ack_q;
    wire wr_ctrl   = ack && avs_write && avs_address == wdtrt_pkg::ADDR_CTRL;
    wire wr_mask   = ack && avs_write && avs_address == wdtrt_pkg::ADDR_MASK;
    // read-clear on the capture edge, so no event slips between capture and clear
    wire rd_stat   = req && avs_read  && avs_address == wdtrt_pkg::ADDR_STATUS;
    wire restart_w = wr_ctrl && avs_writedata[wdtrt_pkg::CTRL_RESTART];  // RQ1
    wire wdt_reset = cfg_if.expire && rst_en_q;                          // RQ2
    wire [1:0] ev  = {wdt_reset, cfg_if.warn};
    wire [1:0] stat_d = (rd_stat ? 2'h0 : stat_q) | ev;                   // set wins
    wire warn_d    = cfg_if.warn ||
                     (warn_flag_q && !(wr_ctrl && !avs_writedata[wdtrt_pkg::CTRL_WARN_FLAG]));
    wire [7:0] ctrl_rd = {1'b0, cause_q, warn_flag_q, 1'b0, irq_en_q, rst_en_q, sel_q};
    wire [31:0] rd_mux =
        (avs_address == wdtrt_pkg::ADDR_CTRL)   ? {24'h0, ctrl_rd} :
        (avs_address == wdtrt_pkg::ADDR_STATUS) ? {30'h0, stat_q} :
        (avs_address == wdtrt_pkg::ADDR_MASK)   ? {30'h0, mask_q} :
        (avs_address == wdtrt_pkg::ADDR_COUNT)  ? {10'h0, cfg_if.count} : 32'h0;

    assign cfg_if.sel     = sel_q;
    assign cfg_if.restart = restart_w;

    wdtrt_counter #(.CNT_W(22)) u_cnt (
        .core_clk (core_clk),
        .rst      (rst),
        .cfg      (cfg_if.core)
    );

    // bus handshake and read data
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_q        <= 1'b0;
            wait_q       <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            ack_q        <= req;
            wait_q       <= !req;
            avs_readdata <= req ? rd_mux : avs_readdata;
        end
    end
    assign avs_waitrequest = wait_q;

    // control register; cause flag survives its own reset pulse
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel_q       <= wdtrt_pkg::SEL_RESET;
            rst_en_q    <= 1'b0;
            irq_en_q    <= 1'b0;
            warn_flag_q <= 1'b0;
            cause_q     <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                sel_q    <= avs_writedata[wdtrt_pkg::CTRL_SEL_LSB +: 2];   // RQ8
                rst_en_q <= avs_writedata[wdtrt_pkg::CTRL_RST_EN];
                irq_en_q <= avs_writedata[wdtrt_pkg::CTRL_IRQ_EN];
            end
            // set wins over software clear
            if (cfg_if.warn) begin
                warn_flag_q <= 1'b1;                                        // RQ7
            end else if (wr_ctrl && !avs_writedata[wdtrt_pkg::CTRL_WARN_FLAG]) begin
                warn_flag_q <= 1'b0;
            end
            if (wdt_reset) begin
                cause_q <= 1'b1;                                            // RQ5
            end else if (wr_ctrl && !avs_writedata[wdtrt_pkg::CTRL_CAUSE]) begin
                cause_q <= 1'b0;
            end
        end
    end

    // sticky status and mask
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stat_q <= 2'h0;
            mask_q <= 2'h0;
        end else begin
            stat_q <= stat_d;                                               // RQ7
            mask_q <= wr_mask ? avs_writedata[1:0] : mask_q;
        end
    end

    // interrupt output: warning flag when enabled, or status bits (warning and reset) gated by mask
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            // next values, so the interrupt leads the reset by the full 512
            irq_q <= (irq_en_q && warn_d) || |(stat_d & mask_q);            // RQ2 RQ4
        end
    end
    assign irq = irq_q;

    // system reset pulse and restart vector
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rpulse_q    <= 5'h00;
            sys_reset_q <= 1'b0;
        end else begin
            if (wdt_reset) begin
                rpulse_q <= 5'(wdtrt_pkg::RESET_PULSE_CLKS);                // RQ2
            end else if (rpulse_q != 5'h00) begin
                rpulse_q <= rpulse_q - 5'h01;
            end
            sys_reset_q <= wdt_reset || (rpulse_q > 5'h01);
        end
    end
    assign sys_reset      = sys_reset_q;

    // restart address, held in a flop so the output is registered
    always_ff @(posedge core_clk) begin
        rvec_q <= wdtrt_pkg::RESTART_VECTOR;                                // RQ6
    end
    assign restart_vector = rvec_q;

    a_rst_cause: assert property (@(posedge core_clk) disable iff (rst)
        wdt_reset |=> cause_q && sys_reset) else $error("cause flag not set"); // RQ5
    a_bus_answer: assert property (@(posedge core_clk) disable iff (rst)
        req |=> !avs_waitrequest) else $error("bus answer late");
    a_warn_sticky: assert property (@(posedge core_clk) disable iff (rst) // RQ7
        cfg_if.warn |=> stat_q[wdtrt_pkg::STAT_WARN] && warn_flag_q)
        else $error("warning flag not set");
    a_irq_lead: assert property (@(posedge core_clk) disable iff (rst) // RQ4
        cfg_if.warn && irq_en_q |=> irq) else $error("interrupt not raised on warning");
    a_reset_len: assert property (@(posedge core_clk) disable iff (rst) // RQ2
        $rose(sys_reset) |-> ##15 sys_reset ##1 !sys_reset)
        else $error("reset pulse length wrong");
endmodule : wdtrt_top

// ### sim/tb.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// self-checking bench for the watchdog reset timer
// ------------------------------------------------------------
module tb;
    logic        core_clk = 1'b0;           // 200 MHz core clock
    logic        rst      = 1'b1;           // sync reset, active high
    logic [3:0]  avs_address   = 4'h0;      // bus address
    logic        avs_read      = 1'b0;      // read strobe
    logic        avs_write     = 1'b0;      // write strobe
    logic [31:0] avs_writedata = 32'h0;     // write data
    logic [31:0] avs_readdata;              // read data
    logic        avs_waitrequest;           // low = answer
    logic        irq;                       // level interrupt
    logic        sys_reset;                 // watchdog reset pulse
    logic [15:0] restart_vector;            // restart address
    int          mismatches = 0;            // failed compares
    int          n_compared = 0;            // all compares
    int          cyc        = 0;            // timeout counter
    int          rst_cycles = 0;            // cycles with reset pulse high
    logic [31:0] q;                         // last read word
    int          n;                         // cycles waited

    wdtrt_top i_wdtrt_top (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .sys_reset(sys_reset), .restart_vector(restart_vector));

    always #2.5 core_clk = ~core_clk;

    // hang guard: the longest run is well under this many cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (sys_reset === 1'b1) rst_cycles <= rst_cycles + 1;
        if (cyc == 40000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // one avalon cycle; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // count edges until irq (w=0) or sys_reset (w=1) is high
    task automatic wait_hi(input int w);
        n = 0;
        while (((w == 0) ? irq : sys_reset) !== 1'b1 && n < 5000) begin
            @(posedge core_clk);
            n++;
        end
    endtask : wait_hi

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_sel;                        // select codes read back, hole reads 0
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, wdtrt_pkg::ADDR_CTRL, 32'(s));
            bus(1'b0, wdtrt_pkg::ADDR_CTRL, 32'h0);
            chk("select", 32'(s), q & 32'h3);
        end
        bus(1'b0, 4'h2, 32'h0);
        chk("hole", 32'h0, q);
    endtask : t_sel

    task automatic t_expire;                     // warning then reset 512 later
        bus(1'b1, wdtrt_pkg::ADDR_MASK, 32'h3);
        bus(1'b1, wdtrt_pkg::ADDR_CTRL, 32'h1C);
        wait_hi(0);
        chk("warn_early", 32'h1, 32'(n < 4096));
        wait_hi(1);
        chk("lead", 32'd512, 32'(n));
        while (sys_reset !== 1'b0) @(posedge core_clk);
        bus(1'b0, wdtrt_pkg::ADDR_CTRL, 32'h0);
        chk("cause", 32'h1, (q >> 6) & 32'h1);
        bus(1'b1, wdtrt_pkg::ADDR_CTRL, 32'h10);
        bus(1'b0, wdtrt_pkg::ADDR_STATUS, 32'h0);
        chk("status", 32'h3, q & 32'h3);
        bus(1'b0, wdtrt_pkg::ADDR_STATUS, 32'h0);
        chk("clear", 32'h0, q & 32'h3);
        chk("irq_off", 32'h0, 32'(irq));
    endtask : t_expire

    task automatic t_masked;                     // flag sets with interrupt off
        int   base;
        logic irq_seen;
        irq_seen = 1'b0;
        bus(1'b1, wdtrt_pkg::ADDR_MASK, 32'h0);
        bus(1'b1, wdtrt_pkg::ADDR_CTRL, 32'h10);
        base = rst_cycles;
        repeat (3700) begin
            @(posedge core_clk);
            if (irq !== 1'b0) irq_seen = 1'b1;
        end
        chk("irq_masked", 32'h0, 32'(irq_seen));
        bus(1'b0, wdtrt_pkg::ADDR_CTRL, 32'h0);
        chk("warn_flag", 32'h1, (q >> 5) & 32'h1);
        chk("no_reset", 32'h0, 32'(rst_cycles - base));
    endtask : t_masked

    task automatic t_kick;                       // periodic restart avoids reset
        int base;
        bus(1'b1, wdtrt_pkg::ADDR_CTRL, 32'h14);
        base = rst_cycles;
        repeat (3) begin
            repeat (3000) @(posedge core_clk);
            bus(1'b1, wdtrt_pkg::ADDR_CTRL, 32'h14);
        end
        bus(1'b0, wdtrt_pkg::ADDR_COUNT, 32'h0);
        chk("count_low", 32'h1, 32'(q < 32'd8));
        chk("kicked", 32'h0, 32'(rst_cycles - base));
    endtask : t_kick

    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk("irq_rst", 32'h0, 32'(irq));
        chk("vector", 32'h8000, 32'(restart_vector));
        t_sel();
        t_expire();
        t_masked();
        t_kick();
        wrap_up();
    end
endmodule : tb
